/* i2c_dac_input_register_test.sv */
// self-checking bench for the dac input register slave
// assumes the master model in i2dr_master.sv and a pull-up on the sda wire
module i2c_dac_input_register_test;
	timeunit 1ns;
	timeprecision 100ps;
	import i2dr_pkg::*;

	logic mclk = 1'b0;
	logic arst_n;
	logic m_scl;
	logic m_oe;
	logic sda_oe;
	logic sda_out;
	logic sleep;
	logic dac_update;
	logic cap_sleep;
	logic ack;
	logic [CODE_W-1:0] dac_code;
	logic [CODE_W-1:0] cap_code;
	logic [15:0] rw;
	logic [7:0] atab [4] = '{8'h18, 8'h1a, 8'h1c, 8'h1e};
	logic [15:0] wtab [4] = '{16'ha55a, 16'h7fff, 16'h8000, 16'hc00f};
	int n_errors = 0;
	int check_count = 0;
	int upd_count = 0;
	wire sda;

	// ----------------------------------------------------------------
	// clock, wire and instances
	// ----------------------------------------------------------------
	initial begin
		forever #5 mclk = ~mclk;
	end

	assign sda = ~(m_oe | sda_oe); // open drain with pull-up

	i2dr_master u_master (.scl(m_scl), .sda_oe(m_oe), .sda(sda));

	i2dr_slave u_dut (.MCLK(mclk), .ARST_N(arst_n), .SCL(m_scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .DAC_CODE(dac_code),
		.SOFT_POWER_DOWN(sleep), .DAC_UPDATE(dac_update));

	// capture outputs mid-cycle while each update pulse stands
	always @(negedge mclk) begin
		if (dac_update === 1'b1) begin
			upd_count++;
			cap_code = dac_code;
			cap_sleep = sleep;
		end
	end

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// bounded wait for the next update pulse
	task automatic wait_upd(input int n0);
		for (int i = 0; i < 100 && upd_count == n0; i++) begin
			@(negedge mclk);
		end
		if (upd_count == n0) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, upd_count, n0 + 1);
			print_verdict();
		end
	endtask

	// ----------------------------------------------------------------
	// transactions
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] adr, input logic [15:0] w, input logic nak,
		input logic extra);
		int n0;
		logic sleep0;
		n0 = upd_count;
		sleep0 = sleep;
		u_master.start();
		u_master.wbyte(adr, ack);
		chk(16'(ack), 16'(!nak));
		if (ack) begin
			u_master.wbyte(w[15:8], ack);
			chk(16'(ack), 16'h0001);
			chk(16'(sleep), 16'(sleep0));
			chk(16'(upd_count - n0), 16'h0000);
			u_master.wbyte(w[7:0], ack);
			chk(16'(ack), 16'h0001);
			wait_upd(n0);
			chk(16'(cap_code), 16'(w[13:4]));
			chk(16'(cap_sleep), 16'(w[15]));
			if (extra) begin
				u_master.wbyte(8'hff, ack);
				chk(16'(ack), 16'h0000);
			end
		end
		u_master.stop();
		chk(16'(upd_count - n0), 16'(!nak));
	endtask

	task automatic rd(input logic [7:0] adr, input logic nak1, input logic [15:0] exp);
		u_master.start();
		u_master.wbyte(adr, ack);
		chk(16'(ack), 16'h0001);
		u_master.rbyte(rw[15:8], ~nak1);
		chk(16'(rw[15:8]), 16'(exp[15:8]));
		if (!nak1) begin
			u_master.rbyte(rw[7:0], 1'b0);
			chk(16'(rw[7:0]), 16'(exp[7:0]));
		end
		u_master.stop();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		repeat (4) @(negedge mclk);
		chk({12'h000, sda_oe, sleep, dac_update, sda_out}, 16'h0000);
		chk(16'(dac_code), 16'h0000);
		arst_n = 1'b1;
		repeat (5) @(negedge mclk);
		// every write address, each data don't-care bit both set and clear
		for (int i = 0; i < 4; i++) begin
			wr(atab[i], wtab[i], 1'b0, i == 3);
		end
		// foreign addresses get no acknowledge
		wr(8'h20, 16'h1234, 1'b1, 1'b0);
		wr(8'h10, 16'h1234, 1'b1, 1'b0);
		// half a word then repeated start: nothing loads
		u_master.start();
		u_master.wbyte(8'h18, ack);
		u_master.wbyte(8'h00, ack);
		u_master.start();
		u_master.stop();
		chk(16'(sleep), 16'h0001);
		chk(16'(cap_code), 16'h0000);
		chk(16'(upd_count), 16'h0004);
		// read back, refused early read keeps it, full read clears it
		wr(8'h18, 16'h9abc, 1'b0, 1'b0);
		rd(8'h19, 1'b1, 16'h9abc);
		rd(8'h1b, 1'b0, 16'h9abc);
		rd(8'h1f, 1'b0, 16'h0000);
		rd(8'h1d, 1'b0, 16'h0000);
		chk(16'(dac_code), 16'h01ab);
		chk(16'(upd_count), 16'h0005);
		print_verdict();
	end

	// hang guard
	initial begin
		#500000;
		n_errors++;
		$display("[ERR] %0t got %h exp %h", $time, 16'h0000, 16'h0001);
		print_verdict();
	end
endmodule // i2c_dac_input_register_test

/* i2dr_master.sv */
// two-wire bus master model that drives the dac input register slave
// assumes an open-drain sda wire with a pull-up that is resolved by the bench
module i2dr_master (
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// idle bus: clock stands high, data released
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// one bit period: 52 ns low, 12 ns high; sample at the rising edge
	task automatic xfer(input logic b, output logic s);
		#8 sda_oe = ~b; // data changes only while the clock is low
		#44 scl = 1'b1;
		s = sda;
		#12 scl = 1'b0;
	endtask

	// start, or repeated start when the clock is low
	task automatic start();
		if (scl == 1'b0) begin
			#8 sda_oe = 1'b0;
			#44 scl = 1'b1;
		end
		#200 sda_oe = 1'b1;
		#200 scl = 1'b0;
		#200;
	endtask

	// stop: data rises while the clock is high, then the bus idles
	task automatic stop();
		#8 sda_oe = 1'b1;
		#44 scl = 1'b1;
		#200 sda_oe = 1'b0;
		#300;
	endtask

	// send one byte and return the slave acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer(b[i], s);
		end
		xfer(1'b1, s);
		ack = ~s;
	endtask

	// receive one byte, then acknowledge or refuse it
	task automatic rbyte(output logic [7:0] b, input logic ack_it);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, b[i]);
		end
		xfer(~ack_it, s);
	endtask
endmodule // i2dr_master

/* i2dr_pin_watch.sv */
// pin watcher: synchronises the bus pins and the word toggle into the system clock
// assumes scl, sda and tgl are asynchronous to mclk
module i2dr_pin_watch (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic tgl,
	i2dr_watch_if.watch w
);
	import i2dr_pkg::*;

	logic [1:0] scl_m, next_scl_m;
	logic [1:0] sda_m, next_sda_m;
	logic [1:0] tgl_m, next_tgl_m;
	logic scl_d, next_scl_d;
	logic sda_d, next_sda_d;
	logic tgl_d, next_tgl_d;

	// ----------------------------------------------------------------
	// two-stage synchronisers plus one delayed copy for edges
	// ----------------------------------------------------------------
	always_comb begin
		next_scl_m = {scl_m[0], scl};
		next_sda_m = {sda_m[0], sda};
		next_tgl_m = {tgl_m[0], tgl};
		next_scl_d = scl_m[1];
		next_sda_d = sda_m[1];
		next_tgl_d = tgl_m[1];
	end

	// idle bus is high, so the scl and sda sync stages reset high to avoid a false start; the toggle stages reset low
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			scl_m <= SYNC_IDLE;
			sda_m <= SYNC_IDLE;
			tgl_m <= SYNC_ZERO;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			tgl_d <= 1'b0;
		end else begin
			scl_m <= next_scl_m;
			sda_m <= next_sda_m;
			tgl_m <= next_tgl_m;
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
			tgl_d <= next_tgl_d;
		end
	end

	// ----------------------------------------------------------------
	// events, from second stage and delayed copy only
	// ----------------------------------------------------------------
	// scl must read high on two samples so data moving just after a fall is not a start
	assign w.scl_high = scl_m[1];
	assign w.start_seen = scl_m[1] & scl_d & sda_d & ~sda_m[1];
	assign w.stop_seen = scl_m[1] & scl_d & ~sda_d & sda_m[1];
	assign w.word_load = tgl_m[1] ^ tgl_d;

endmodule // i2dr_pin_watch

/* i2dr_pkg.sv */
// constants and types shared by the two-byte dac input register slave
// assumes nothing beyond a simulator or synthesis tool that reads packages
package i2dr_pkg;

	// ----------------------------------------------------------------
	// input register layout
	// ----------------------------------------------------------------
	localparam int INPUT_W = 16;
	localparam int BYTE_W = 8;
	localparam int CODE_W = 10;
	localparam int SLEEP_BIT = 15;
	localparam int CODE_HI = 13;
	localparam int CODE_LO = 4;
	localparam logic [INPUT_W-1:0] INPUT_RST = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
	localparam logic SLEEP_RST = 1'b0;

	// ----------------------------------------------------------------
	// serial framing
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_MATCH = 5'h03;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [1:0] SYNC_IDLE = 2'h3;
	localparam logic [1:0] SYNC_ZERO = 2'h0;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_ADDR, ST_WR, ST_RD, ST_IGNORE} i2dr_link_state_t;
	typedef enum logic [1:0] {FR_IDLE, FR_ARMED, FR_RUN} i2dr_frame_t;

endpackage

/* i2dr_slave.sv */
// two-byte dac input register behind a serial two-wire slave
// assumes an external master clocks scl, a pull-up on sda and an asynchronous mclk
//
// What this block does
// - bytes arrive high byte first and msb first, shifting into the 16-bit input register.
// - once all sixteen bits are in, the input register is copied into the dac register.
// - input register bit 15 is an active-high soft power-down request.
// - input register bits 13 down to 4 form the 10-bit converter code, msb at bit 13.
// - input register bit 14 and bits 3 down to 0 are stored and read back but never reach the dac.
// - a read returns the register high byte first and msb first, as a write fills it.
// - the slave answers only when the upper five address bits match the fixed pattern.
// - when a read of both bytes completes, the input register is cleared to zero.
// - the slave acknowledges the address byte and each of the two data bytes of a write.
module i2dr_slave (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	output logic [i2dr_pkg::CODE_W-1:0] DAC_CODE,
	output logic SOFT_POWER_DOWN,
	output logic DAC_UPDATE
);
	import i2dr_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	i2dr_link_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic byte_idx, next_byte_idx;
	logic [6:0] addr_sh, next_addr_sh;
	logic addr_ok, next_addr_ok;
	logic rw, next_rw;
	logic tgl, next_tgl;
	logic [INPUT_W-1:0] input_reg, next_input_reg;
	logic sda_oe, next_sda_oe;
	logic sda_o;
	i2dr_frame_t fr_state, next_fr_state;
	logic link_rst_n, next_link_rst_n;
	logic [CODE_W-1:0] dac_code, next_dac_code;
	logic soft_power_down, next_soft_power_down;
	logic dac_update, next_dac_update;

	i2dr_watch_if w ();

	// bit position of the read bit for a given byte and bit count
	function automatic logic [3:0] rd_index(input logic sel, input logic [3:0] bit_cnt);
		rd_index = {~sel, LAST_BIT[2:0] - bit_cnt[2:0]};
	endfunction

	// ----------------------------------------------------------------
	// pin watcher
	// ----------------------------------------------------------------
	i2dr_pin_watch u_watch (
		.mclk(MCLK),
		.arst_n(ARST_N),
		.scl(SCL),
		.sda(SDA_IN),
		.tgl(tgl),
		.w(w.watch)
	);

	// ----------------------------------------------------------------
	// frame tracker on mclk: holds the link logic in reset outside a frame
	// ----------------------------------------------------------------
	// the release waits for scl low, so no scl edge lies near it
	always_comb begin
		next_fr_state = fr_state;
		if (w.start_seen) begin
			next_fr_state = FR_ARMED; // repeated start restarts the frame
		end else if (w.stop_seen) begin
			next_fr_state = FR_IDLE;
		end else if (fr_state == FR_ARMED && !w.scl_high) begin
			next_fr_state = FR_RUN;
		end
		next_link_rst_n = (next_fr_state == FR_RUN);
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fr_state <= FR_IDLE;
			link_rst_n <= 1'b0;
		end else begin
			fr_state <= next_fr_state;
			link_rst_n <= next_link_rst_n;
		end
	end

	// ----------------------------------------------------------------
	// byte sequencing on rising scl
	// ----------------------------------------------------------------
	// cnt 0..7 are data bits, 8 is the acknowledge slot
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_byte_idx = byte_idx;
		next_addr_ok = addr_ok;
		next_rw = rw;
		next_tgl = tgl;
		next_addr_sh = {addr_sh[5:0], SDA_IN};
		if (cnt != ACK_SLOT) begin
			next_cnt = cnt + 4'h1;
			if (state == ST_ADDR && cnt == LAST_BIT) begin
				next_addr_ok = (addr_sh[6:2] == ADDR_MATCH);
				next_rw = SDA_IN;
			end
			if (state == ST_WR && cnt == LAST_BIT && byte_idx) begin
				next_tgl = ~tgl;
			end
		end else begin
			next_cnt = 4'h0;
			case (state)
				ST_ADDR: begin
					if (!addr_ok) begin
						next_state = ST_IGNORE;
					end else if (rw) begin
						next_state = ST_RD;
					end else begin
						next_state = ST_WR;
					end
				end
				ST_WR: begin
					next_byte_idx = 1'b1;
					if (byte_idx) begin
						next_state = ST_IGNORE;
					end
				end
				ST_RD: begin
					next_byte_idx = 1'b1;
					if (byte_idx || SDA_IN) begin
						next_state = ST_IGNORE;
					end
				end
				default: begin
					next_state = ST_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state <= ST_ADDR;
			cnt <= 4'h0;
			byte_idx <= 1'b0;
			addr_sh <= 7'h00;
			addr_ok <= 1'b0;
			rw <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			byte_idx <= next_byte_idx;
			addr_sh <= next_addr_sh;
			addr_ok <= next_addr_ok;
			rw <= next_rw;
		end
	end

	// toggle survives frame resets so each loaded word flips it exactly once
	always_ff @(posedge SCL or negedge ARST_N) begin
		if (!ARST_N) begin
			tgl <= 1'b0;
		end else begin
			tgl <= next_tgl;
		end
	end

	// ----------------------------------------------------------------
	// input register on rising scl
	// ----------------------------------------------------------------
	// unused bits are shifted and read back but never reach the dac
	always_comb begin
		next_input_reg = input_reg;
		if (state == ST_WR && cnt != ACK_SLOT) begin
			next_input_reg = {input_reg[INPUT_W-2:0], SDA_IN};
		end else if (state == ST_RD && cnt == ACK_SLOT && byte_idx) begin
			next_input_reg = INPUT_RST;
		end
	end

	always_ff @(posedge SCL or negedge ARST_N) begin
		if (!ARST_N) begin
			input_reg <= INPUT_RST;
		end else begin
			input_reg <= next_input_reg;
		end
	end

	// ----------------------------------------------------------------
	// sda drive on falling scl
	// ----------------------------------------------------------------
	// changes only while scl is low, so it never fakes a start or stop
	always_comb begin
		next_sda_oe = 1'b0;
		if (cnt == ACK_SLOT) begin
			next_sda_oe = (state == ST_ADDR && addr_ok) || state == ST_WR;
		end else if (state == ST_RD) begin
			next_sda_oe = ~input_reg[rd_index(byte_idx, cnt)];
		end
	end

	always_ff @(negedge SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sda_oe <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
			sda_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// dac register on mclk
	// ----------------------------------------------------------------
	// input_reg is steady for many mclk cycles around a toggle, so it is read directly
	always_comb begin
		next_dac_code = dac_code;
		next_soft_power_down = soft_power_down;
		next_dac_update = w.word_load;
		if (w.word_load) begin
			next_dac_code = input_reg[CODE_HI:CODE_LO];
			next_soft_power_down = input_reg[SLEEP_BIT];
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dac_code <= CODE_RST;
			soft_power_down <= SLEEP_RST;
			dac_update <= 1'b0;
		end else begin
			dac_code <= next_dac_code;
			soft_power_down <= next_soft_power_down;
			dac_update <= next_dac_update;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign SDA_OUT = sda_o;
	assign SDA_OE = sda_oe;
	assign DAC_CODE = dac_code;
	assign SOFT_POWER_DOWN = soft_power_down;
	assign DAC_UPDATE = dac_update;

	// ----------------------------------------------------------------
	// checks on the scl side
	// ----------------------------------------------------------------
	a_shift_order: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_WR && cnt != ACK_SLOT) |=>
		input_reg == {$past(input_reg[INPUT_W-2:0]), $past(SDA_IN)})
		else $error("write bit not shifted in msb first");

	a_word_toggle: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_WR && cnt == LAST_BIT && byte_idx) |=> (tgl != $past(tgl)))
		else $error("sixteenth bit did not flip the word toggle");

	a_addr_ack: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(cnt == ACK_SLOT && (state == ST_WR || (state == ST_ADDR && addr_ok))) |-> sda_oe)
		else $error("missing acknowledge");

	a_foreign_quiet: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_IGNORE || (state == ST_ADDR && cnt != ACK_SLOT)) |-> !sda_oe)
		else $error("sda driven outside own frame");

	a_read_order: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_RD && cnt != ACK_SLOT) |->
		(sda_oe == !input_reg[rd_index(byte_idx, cnt)]))
		else $error("read bit out of order");

	a_read_clear: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_RD && cnt == ACK_SLOT && byte_idx) |=> input_reg == INPUT_RST)
		else $error("input register not cleared after read");

	a_two_bytes: assert property (@(posedge SCL) disable iff (!link_rst_n)
		(state == ST_WR && cnt == ACK_SLOT && byte_idx) |=> state == ST_IGNORE)
		else $error("third data byte accepted");

	// ----------------------------------------------------------------
	// checks on the mclk side
	// ----------------------------------------------------------------
	a_update_latency: assert property (@(posedge MCLK) disable iff (!ARST_N)
		$changed(tgl) |-> ##[2:4] dac_update)
		else $error("dac register not loaded after a full word");

	a_code_load: assert property (@(posedge MCLK) disable iff (!ARST_N)
		dac_update |-> dac_code == $past(input_reg[CODE_HI:CODE_LO]))
		else $error("dac code not taken from bits 13 to 4");

	a_sleep_load: assert property (@(posedge MCLK) disable iff (!ARST_N)
		dac_update |-> soft_power_down == $past(input_reg[SLEEP_BIT]))
		else $error("power-down not taken from bit 15");

	a_reg_hold: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!dac_update |-> ($stable(soft_power_down) && $stable(dac_code)))
		else $error("dac register changed without a load");

	a_update_pulse: assert property (@(posedge MCLK) disable iff (!ARST_N)
		dac_update |=> !dac_update)
		else $error("update pulse longer than one cycle");

	a_start_arms: assert property (@(posedge MCLK) disable iff (!ARST_N)
		w.start_seen |=> (fr_state == FR_ARMED && !link_rst_n))
		else $error("start did not rearm the frame");

	a_stop_holds: assert property (@(posedge MCLK) disable iff (!ARST_N)
		(w.stop_seen && !w.start_seen) |=> !link_rst_n)
		else $error("link not held after stop");

endmodule // i2dr_slave

/* i2dr_watch_if.sv */
// carrier between the pin watcher and the register slave top
// assumes both ends run on the system clock
interface i2dr_watch_if;
	logic scl_high;
	logic start_seen;
	logic stop_seen;
	logic word_load;

	modport watch (output scl_high, output start_seen, output stop_seen, output word_load);
	modport user (input scl_high, input start_seen, input stop_seen, input word_load);
endinterface
